//--- verilog/uimsk_defines.vh
`ifndef UIMSK_DEFINES_VH
`define UIMSK_DEFINES_VH
`define UIMSK_OFS_MASK 12'h038
`define UIMSK_OFS_RAW 12'h03c
`define UIMSK_OFS_MSK 12'h040
`define UIMSK_OFS_CLR 12'h044
`define UIMSK_OFS_LVL 12'h034
`define UIMSK_OFS_CTL 12'h030
`define UIMSK_NSRC 11
`define UIMSK_BIT_OE 10
`define UIMSK_BIT_BE 9
`define UIMSK_BIT_PE 8
`define UIMSK_BIT_FE 7
`define UIMSK_BIT_RT 6
`define UIMSK_BIT_TX 5
`define UIMSK_BIT_RX 4
`define UIMSK_BIT_DSR 3
`define UIMSK_BIT_DCD 2
`define UIMSK_BIT_CTS 1
`define UIMSK_BIT_RI 0
`define UIMSK_MASK_RST 11'h000
`define UIMSK_LVL_RST 6'h12
`define UIMSK_CTL_RST 1'b0
`define UIMSK_CTL_BIT_IR 1
`endif

//--- verilog/uimsk_level.v
`timescale 1ns/10ps
`default_nettype none
// Compares a buffer occupancy against a selected eighth-based fraction.
module uimsk_level #(
    parameter DEPTH_W = 5
) (
    input wire [DEPTH_W:0] occupancy,
    input wire [2:0] level_sel,
    input wire at_or_above,
    output wire hit
);
    wire [DEPTH_W+3:0] occ8;
    reg [3:0] eighths;
    wire [DEPTH_W+3:0] thr;
    always @* begin
        case (level_sel)
            3'b000: eighths = 4'h1;
            3'b001: eighths = 4'h2;
            3'b010: eighths = 4'h4;
            3'b011: eighths = 4'h6;
            default: eighths = 4'h7;
        endcase
    end
    assign occ8 = {occupancy, 3'b000};
    // The threshold in eighths is the fraction count times the full depth.
    assign thr = {eighths, {DEPTH_W{1'b0}}};
    assign hit = at_or_above ? (occ8 >= thr) : (occ8 <= thr);
endmodule
`default_nettype wire

//--- verilog/uimsk_top.v
// Summary of operation
// [RL1] Error masks at bits ten down to seven.
// [RL2] Timeout, transmit, receive masks at bits 6-4.
// [RL3] Modem masks at bits three down to zero.
// [RL4] Mask bits written directly and read back.
// [RL5] All mask bits reset to zero.
// [RL6] Raw status is read-only, mask independent.
// [RL7] Error and flow raw bits reset zero.
// [RL8] Masked status is raw AND mask.
// [RL9] Error and flow masked bits reset zero.
// [RL10] Modem status bits follow external inputs.
// [RL11] Writing one to clear register clears pending.
// [RL12] Clear register uses mask bit mapping.
// [RL13] Bits 31 to 11 are reserved.
// [RL14] Level sources compare occupancy to fractions.
// [RL15] Infrared mode ignores modem input transitions.
// [RL16] Writing zero to clear does nothing.
// [RL17] Reserved bits read zero, writes ignored.
// [RL18] Combined interrupt when any masked bit set.
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "uimsk_defines.vh"
module uimsk_top #(
    parameter DEPTH_W = 5
) (
    input wire core_clk,
    input wire rst_b,
    input wire [11:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    input wire overrun_event,
    input wire break_event,
    input wire parity_event,
    input wire framing_event,
    input wire rx_timeout_event,
    input wire [DEPTH_W:0] rx_occupancy,
    input wire [DEPTH_W:0] tx_occupancy,
    input wire set_ready_in,
    input wire carrier_detect_in,
    input wire clear_to_send_in,
    input wire ring_indicator_in,
    output wire uart_irq
);
    reg [10:0] mask_r;
    reg [10:0] pend_r;
    reg [5:0] lvl_r;
    reg [1:0] ctl_r;
    reg [3:0] modem_r;
    reg ack_r;
    reg rx_hit_r;
    reg tx_hit_r;
    wire rx_hit;
    wire tx_hit;
    wire [10:0] set_ev;
    wire [10:0] clr_ev;
    wire [10:0] masked;
    wire [3:0] modem_in;
    wire [3:0] modem_chg;
    wire acc;
    wire wr_go;
    wire rd_go;
    wire lo_ok;
    wire hi_ok;

    // Every access is answered one cycle after it is presented.
    assign acc = avs_read | avs_write;
    assign avs_waitrequest = acc & ~ack_r;
    assign wr_go = avs_write & ack_r;
    assign rd_go = avs_read & ~ack_r;
    assign lo_ok = avs_byteenable[0];
    assign hi_ok = avs_byteenable[1];

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= acc & ~ack_r;
        end
    end

    uimsk_level #(.DEPTH_W(DEPTH_W)) u_rx_level (
        .occupancy(rx_occupancy),
        .level_sel(lvl_r[5:3]),
        .at_or_above(1'b1),
        .hit(rx_hit)
    ); // [RL14]
    uimsk_level #(.DEPTH_W(DEPTH_W)) u_tx_level (
        .occupancy(tx_occupancy),
        .level_sel(lvl_r[2:0]),
        .at_or_above(1'b0),
        .hit(tx_hit)
    ); // [RL14]

    assign modem_in = {set_ready_in, carrier_detect_in, clear_to_send_in,
        ring_indicator_in};
    // Modem changes are ignored while the infrared codec is enabled.
    assign modem_chg = (modem_in ^ modem_r) &
        {4{~ctl_r[`UIMSK_CTL_BIT_IR]}}; // [RL15] [RL10]

    assign set_ev[`UIMSK_BIT_OE] = overrun_event;
    assign set_ev[`UIMSK_BIT_BE] = break_event;
    assign set_ev[`UIMSK_BIT_PE] = parity_event;
    assign set_ev[`UIMSK_BIT_FE] = framing_event;
    assign set_ev[`UIMSK_BIT_RT] = rx_timeout_event;
    assign set_ev[`UIMSK_BIT_TX] = tx_hit & ~tx_hit_r; // [RL14]
    assign set_ev[`UIMSK_BIT_RX] = rx_hit & ~rx_hit_r; // [RL14]
    assign set_ev[`UIMSK_BIT_DSR] = modem_chg[3];
    assign set_ev[`UIMSK_BIT_DCD] = modem_chg[2];
    assign set_ev[`UIMSK_BIT_CTS] = modem_chg[1];
    assign set_ev[`UIMSK_BIT_RI] = modem_chg[0];

    // Ones clear pending bits, zeros leave them alone.
    assign clr_ev = (wr_go && avs_address == `UIMSK_OFS_CLR) ?
        {avs_writedata[10:8] & {3{hi_ok}}, avs_writedata[7:0] & {8{lo_ok}}}
        : 11'h000; // [RL11] [RL12] [RL16] [RL13]

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            modem_r <= 4'h0;
            rx_hit_r <= 1'b0;
            tx_hit_r <= 1'b0;
        end else begin
            modem_r <= modem_in;
            rx_hit_r <= rx_hit;
            tx_hit_r <= tx_hit;
        end
    end

    // A source event in the clear cycle wins over the clear.
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pend_r <= 11'h000; // [RL7]
        end else begin
            pend_r <= (pend_r & ~clr_ev) | set_ev; // [RL6] [RL11]
        end
    end

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            mask_r <= `UIMSK_MASK_RST; // [RL5]
            lvl_r <= `UIMSK_LVL_RST;
            ctl_r <= {`UIMSK_CTL_RST, 1'b0};
        end else if (wr_go) begin
            if (avs_address == `UIMSK_OFS_MASK) begin
                if (lo_ok) begin
                    mask_r[7:0] <= avs_writedata[7:0]; // [RL4] [RL1]
                end
                if (hi_ok) begin
                    mask_r[10:8] <= avs_writedata[10:8]; // [RL1] [RL17]
                end
            end else if (avs_address == `UIMSK_OFS_LVL) begin
                if (lo_ok) begin
                    lvl_r <= avs_writedata[5:0];
                end
            end else if (avs_address == `UIMSK_OFS_CTL) begin
                if (lo_ok) begin
                    ctl_r <= {avs_writedata[`UIMSK_CTL_BIT_IR], 1'b0};
                end
            end
        end
    end

    assign masked = pend_r & mask_r; // [RL8] [RL9] [RL2] [RL3]
    assign uart_irq = |masked; // [RL18]

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            avs_readdata <= 32'h0000_0000;
        end else if (rd_go) begin
            if (avs_address == `UIMSK_OFS_MASK) begin
                avs_readdata <= {21'h00_0000, mask_r}; // [RL4] [RL17]
            end else if (avs_address == `UIMSK_OFS_RAW) begin
                avs_readdata <= {21'h00_0000, pend_r}; // [RL6] [RL13]
            end else if (avs_address == `UIMSK_OFS_MSK) begin
                avs_readdata <= {21'h00_0000, masked}; // [RL8]
            end else if (avs_address == `UIMSK_OFS_LVL) begin
                avs_readdata <= {26'h000_0000, lvl_r};
            end else if (avs_address == `UIMSK_OFS_CTL) begin
                avs_readdata <= {30'h0000_0000, ctl_r};
            end else begin
                avs_readdata <= 32'h0000_0000;
            end
        end
    end
endmodule
`default_nettype wire

//--- tb/uimsk_properties.sv
`timescale 1ns/10ps
`default_nettype none
module uimsk_properties (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [11:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic overrun_event,
    input wire logic uart_irq
);
    wire req = avs_read | avs_write;
    wire rd_done = avs_read & ~avs_waitrequest;
    wire wr_done = avs_write & ~avs_waitrequest & (&avs_byteenable[1:0]);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    a_wait_first: assert property (req && !$past(req) |-> avs_waitrequest)
        else $error("request not held off in its first cycle");
    a_wait_one: assert property (req && avs_waitrequest |=> !avs_waitrequest)
        else $error("request held off longer than one cycle");
    a_wait_idle: assert property (!req |-> !avs_waitrequest)
        else $error("waitrequest high while idle");
    a_irq_reset: assert property ($rose(rst_b) |-> !uart_irq)
        else $error("interrupt high right after reset");
    a_resv_zero: assert property (rd_done |-> avs_readdata[31:11] == 21'h0)
        else $error("reserved read bits not zero");
    a_mask_off: assert property (wr_done && avs_address == 12'h038 &&
        avs_writedata[10:0] == 11'h0 |=> !uart_irq)
        else $error("interrupt high with all sources masked");
    a_irq_mis: assert property (rd_done && avs_address == 12'h040 |->
        (|avs_readdata[10:0]) == $past(uart_irq))
        else $error("interrupt output disagrees with masked status");
    a_raw_set: assert property (rd_done && avs_address == 12'h03c &&
        $past(overrun_event, 2) |-> avs_readdata[10])
        else $error("overrun raw status not set by event");
endmodule
bind uimsk_top uimsk_properties u_chk (.core_clk, .rst_b, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .overrun_event, .uart_irq);
`default_nettype wire

//--- tb/test_uart_interrupt_mask_status.sv
`timescale 1ns/10ps
`default_nettype none
module test_uart_interrupt_mask_status;
    logic core_clk, rst_b, rd, wr, uart_irq, wreq;
    logic [11:0] adr;
    logic [31:0] wdat, rdat, avs_readdata;
    logic [4:0] ev;
    logic [3:0] md;
    logic [5:0] rxo, txo;
    int miscompares = 0;
    int num_checks = 0;
    uimsk_top u_uimsk_top (.core_clk(core_clk), .rst_b(rst_b),
        .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wdat), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(wreq),
        .overrun_event(ev[4]), .break_event(ev[3]), .parity_event(ev[2]),
        .framing_event(ev[1]), .rx_timeout_event(ev[0]),
        .rx_occupancy(rxo), .tx_occupancy(txo), .set_ready_in(md[3]),
        .carrier_detect_in(md[2]), .clear_to_send_in(md[1]),
        .ring_indicator_in(md[0]), .uart_irq(uart_irq));
    always #2 core_clk = ~core_clk;
    task automatic chk(input string s, input [31:0] seen, input [31:0] e);
        num_checks++;
        if (seen !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", s, e, seen);
        end
    endtask
    task automatic bus(input bit w, input [11:0] a, input [31:0] wd);
        @(posedge core_clk);
        adr <= a; wdat <= wd; wr <= w; rd <= !w;
        do @(posedge core_clk); while (wreq !== 1'b0);
        rdat = avs_readdata; wr <= 1'b0; rd <= 1'b0;
    endtask
    task automatic rc(input [11:0] a, input [31:0] e, input string s);
        bus(1'b0, a, 32'h0000_0000);
        chk(s, rdat, e);
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #20000;
        miscompares++;
        print_verdict;
    end
    initial begin
        core_clk = 0; rst_b = 0; adr = 0; wdat = 0; rd = 0; wr = 0;
        ev = 0; md = 0; rxo = 6'h00; txo = 6'h20;
        repeat (6) @(posedge core_clk);
        rst_b <= 1'b1;
        rc(12'h038, 32'h0000_0000, "mask");
        rc(12'h03c, 32'h0000_0000, "raw");
        rc(12'h040, 32'h0000_0000, "masked");
        bus(1'b1, 12'h038, 32'hffff_ffff);
        rc(12'h038, 32'h0000_07ff, "mask");
        bus(1'b1, 12'h038, 32'h0000_0000);
        rc(12'h100, 32'h0000_0000, "unmapped");
        for (int i = 0; i < 5; i++) begin
            @(posedge core_clk) ev <= 5'h01 << i;
            @(posedge core_clk) ev <= 5'h00;
            rc(12'h03c, 32'h0000_0040 << i, "raw");
            bus(1'b1, 12'h044, 32'h0000_0000);
            rc(12'h03c, 32'h0000_0040 << i, "raw");
            bus(1'b1, 12'h044, 32'h0000_0040 << i);
            rc(12'h03c, 32'h0000_0000, "raw");
        end
        for (int j = 0; j < 4; j++) begin
            @(posedge core_clk) md <= md ^ (4'h1 << j);
            rc(12'h03c, 32'h0000_0001 << j, "raw");
            bus(1'b1, 12'h044, 32'h0000_0001 << j);
        end
        @(posedge core_clk) ev <= 5'h10;
        @(posedge core_clk) ev <= 5'h00;
        bus(1'b1, 12'h038, 32'h0000_0400);
        rc(12'h040, 32'h0000_0400, "masked");
        chk("irq", {31'h0, uart_irq}, 32'h0000_0001);
        bus(1'b1, 12'h038, 32'h0000_0000);
        rc(12'h040, 32'h0000_0000, "masked");
        rc(12'h03c, 32'h0000_0400, "raw");
        chk("irq", {31'h0, uart_irq}, 32'h0000_0000);
        bus(1'b1, 12'h044, 32'h0000_07ff);
        @(posedge core_clk) begin
            rxo <= 6'h10;
            txo <= 6'h10;
        end
        repeat (4) @(posedge core_clk);
        rc(12'h03c, 32'h0000_0030, "raw");
        bus(1'b1, 12'h044, 32'h0000_07ff);
        bus(1'b1, 12'h030, 32'h0000_0002);
        @(posedge core_clk) md <= md ^ 4'h2;
        rc(12'h03c, 32'h0000_0000, "raw");
        print_verdict;
    end
endmodule
`default_nettype wire
